// ==== hw/hse_pkg.sv ====
/*
 * Constants for the header suppression engine: register map, field
 * positions, stream alignment offsets, error set sizes and states.
 * Assumes an APB master with 32-bit data and a byte stream on each side.
 */
// How it works
// - Upstream field starts right after checksum.
// - Downstream field starts at thirteenth byte.
// - Field MSB matches first covered byte.
// - Stored field length equals configured size.
// - Index must be 1 to 255; here index 0 only sets ST_INDEX_BAD and suppression still runs.
// - Mask spans size over eight, rounded up.
// - Mask one: sender drops, receiver restores cached.
// - Mask zero: sender keeps, receiver takes packet.
// - No mask means suppress every byte.
// - Suppress exactly size bytes following mask.
// - Size zero disables, non-zero enables suppression; here a size above FLD_MAX also disables.
// - No suppression while rule partially defined.
// - Verify select 0 verifies, default verify.
// - Only sender verifies masked bytes first.
// - Any mismatch forwards header unsuppressed.
// - Error set has one subtype byte.
// - Error code single non-zero byte.
// - At most one zero-terminated error text.
// - Whole encoding shorter than 256 bytes.
// - Error encodings only for rejected rules.
// - Vendor container needs vendor identifier first.
package hse_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] OFF_CTRL   = 12'h000;
    localparam logic [11:0] OFF_SIZE   = 12'h004;
    localparam logic [11:0] OFF_INDEX  = 12'h008;
    localparam logic [11:0] OFF_MASK   = 12'h00C;
    localparam logic [11:0] OFF_STATUS = 12'h010;
    localparam logic [11:0] OFF_ERRSET = 12'h014;
    localparam logic [11:0] OFF_ERRLEN = 12'h018;
    localparam logic [11:0] OFF_VENDOR = 12'h01C;
    localparam logic [11:0] OFF_COUNT  = 12'h020;
    localparam logic [11:0] OFF_FIELD  = 12'h040;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_RX      = 0;
    localparam int CTRL_DOWN    = 1;
    localparam int CTRL_NOVFY   = 2;
    localparam int CTRL_MASK    = 3;
    localparam int CTRL_CLEAR   = 4;
    localparam int ST_ACTIVE    = 0;
    localparam int ST_SIZE_OK   = 1;
    localparam int ST_FIELD_OK  = 2;
    localparam int ST_INDEX_BAD = 3;
    localparam int ST_BUSY      = 4;
    localparam int ST_ERR_VALID = 5;
    localparam int ST_VEND_DISC = 6;
    localparam int ST_VFY_FAIL  = 7;

    // ------------------------------------------------------------------
    // Alignment, encoding sizes and reset values
    // ------------------------------------------------------------------
    localparam logic [5:0] DN_SKIP      = 6'h0C;
    localparam logic [8:0] ENC_HDR      = 9'h002;
    localparam logic [8:0] ONE_BYTE_TLV = 9'h003;
    localparam logic [8:0] TLV_HDR      = 9'h002;
    localparam logic [8:0] ENC_LIMIT    = 9'h100;
    localparam logic [7:0] VENDOR_ID_T  = 8'h08;
    localparam logic [7:0] CODE_OKAY    = 8'h00;
    localparam logic [31:0] RST_MASK    = 32'hFFFFFFFF;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_SKIP = 6'h02,
        S_COLL = 6'h04,
        S_EMIT = 6'h08,
        S_REST = 6'h10,
        S_PASS = 6'h20
    } hse_state_t;

endpackage

// ==== hw/hse_top.sv ====
/*
 * Header suppression engine: sender side suppresses (with optional
 * verification), receiver side restores, plus error set checking and
 * the APB register file. Assumes in_* and out_* are synchronous to pclk.
 */
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module hse_top #(
    parameter int FLD_MAX = 16
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        in_valid,
    output logic             in_ready,
    input  wire logic [7:0]  in_data,
    input  wire logic        in_last,
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic      [7:0]  out_data,
    output logic             out_last
);

    localparam int NWORD = FLD_MAX / 4;

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (FLD_MAX < 4 || FLD_MAX > 32 || (FLD_MAX % 4) != 0)
    begin : g_bad
        $error("FLD_MAX must be a multiple of 4 from 4 to 32");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        hse_pkg::hse_state_t          state;
        logic [5:0]                   cnt;
        logic [5:0]                   n;
        logic                         fail;
        logic                         short_pkt;
        logic                         tlast;
        logic                         rx;
        logic                         down;
        logic                         novfy;
        logic                         mpres;
        logic [7:0]                   size;
        logic                         size_known;
        logic                         field_known;
        logic [7:0]                   index;
        logic [31:0]                  mask;
        logic [FLD_MAX-1:0][7:0]      fld;
        logic [FLD_MAX-1:0][7:0]      hold;
        logic                         vfail;
        logic [7:0]                   err_sub;
        logic [7:0]                   err_code;
        logic [7:0]                   err_mlen;
        logic                         err_valid;
        logic [8:0]                   err_len;
        logic [7:0]                   vend_type;
        logic                         vend_disc;
        logic [15:0]                  sup_cnt;
        logic [15:0]                  fail_cnt;
        logic [31:0]                  rdata;
        logic                         ovalid;
        logic [7:0]                   odata;
        logic                         olast;
    } hse_regs_t;

    hse_regs_t r_q;
    hse_regs_t r_d;

    logic        active;
    logic        oslot;
    logic        in_fire;
    logic        drop;
    logic        wr_en;
    logic        rd_set;
    logic        mapped;
    logic        fld_hit;
    logic [31:0] rd_mux;
    logic [8:0]  enc_total;

    // Mask bit i is value bit 31-i, so bit 0 is the MSB; absent mask
    // reads as all ones.
    function automatic logic mbit(input hse_regs_t r, input logic [5:0] i);
        mbit = r.mpres ? r.mask[5'(31 - i)] : 1'b1;
    endfunction

    // A rule works only when size and field are both known, the size is
    // non-zero and fits the field store.
    assign active = r_q.size_known && r_q.field_known
                  && (r_q.size != 8'h00)
                  && (r_q.size <= 8'(FLD_MAX));

    assign oslot   = !r_q.ovalid || out_ready;
    assign in_fire = in_valid && in_ready;
    assign drop    = mbit(r_q, r_q.cnt) && !r_q.fail && !r_q.short_pkt;

    assign wr_en   = psel && penable && pwrite;
    assign rd_set  = psel && !penable;
    assign fld_hit = (paddr >= hse_pkg::OFF_FIELD)
                  && (paddr < hse_pkg::OFF_FIELD + 12'(4 * NWORD))
                  && (paddr[1:0] == 2'h0);
    assign mapped  = fld_hit || (paddr <= hse_pkg::OFF_COUNT
                  && paddr[1:0] == 2'h0);

    assign enc_total = hse_pkg::ENC_HDR + hse_pkg::ONE_BYTE_TLV
                     + hse_pkg::ONE_BYTE_TLV
                     + ((pwdata[23:16] != 8'h00)
                        ? hse_pkg::TLV_HDR + 9'(pwdata[23:16]) : 9'h000);

    // ------------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------------
    always_comb
    begin
        rd_mux = 32'h00000000;
        case (paddr)
            hse_pkg::OFF_CTRL:
            begin
                rd_mux[hse_pkg::CTRL_RX]    = r_q.rx;
                rd_mux[hse_pkg::CTRL_DOWN]  = r_q.down;
                rd_mux[hse_pkg::CTRL_NOVFY] = r_q.novfy;
                rd_mux[hse_pkg::CTRL_MASK]  = r_q.mpres;
            end
            hse_pkg::OFF_SIZE:   rd_mux[7:0] = r_q.size;
            hse_pkg::OFF_INDEX:  rd_mux[7:0] = r_q.index;
            hse_pkg::OFF_MASK:   rd_mux = r_q.mask;
            hse_pkg::OFF_STATUS:
            begin
                rd_mux[hse_pkg::ST_ACTIVE]    = active;
                rd_mux[hse_pkg::ST_SIZE_OK]   = r_q.size_known;
                rd_mux[hse_pkg::ST_FIELD_OK]  = r_q.field_known;
                rd_mux[hse_pkg::ST_INDEX_BAD] = (r_q.index == 8'h00);
                rd_mux[hse_pkg::ST_BUSY]      = (r_q.state != hse_pkg::S_IDLE);
                rd_mux[hse_pkg::ST_ERR_VALID] = r_q.err_valid;
                rd_mux[hse_pkg::ST_VEND_DISC] = r_q.vend_disc;
                rd_mux[hse_pkg::ST_VFY_FAIL]  = r_q.vfail;
            end
            hse_pkg::OFF_ERRSET:
                rd_mux[23:0] = {r_q.err_mlen, r_q.err_code, r_q.err_sub};
            hse_pkg::OFF_ERRLEN: rd_mux[8:0] = r_q.err_len;
            hse_pkg::OFF_VENDOR: rd_mux[7:0] = r_q.vend_type;
            hse_pkg::OFF_COUNT:  rd_mux = {r_q.fail_cnt, r_q.sup_cnt};
            default:
            begin
                for (int w = 0; w < NWORD; w++)
                begin
                    if (paddr == hse_pkg::OFF_FIELD + 12'(4 * w))
                    begin
                        // Lower field index sits in the higher byte.
                        rd_mux = {r_q.fld[4*w], r_q.fld[4*w+1],
                                  r_q.fld[4*w+2], r_q.fld[4*w+3]};
                    end
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        r_d      = r_q;
        in_ready = 1'b0;
        if (rd_set)
        begin
            r_d.rdata = rd_mux;
        end
        if (out_ready)
        begin
            r_d.ovalid = 1'b0;
        end

        // Register writes.
        if (wr_en)
        begin
            case (paddr)
                hse_pkg::OFF_CTRL:
                begin
                    r_d.rx    = pwdata[hse_pkg::CTRL_RX];
                    r_d.down  = pwdata[hse_pkg::CTRL_DOWN];
                    r_d.novfy = pwdata[hse_pkg::CTRL_NOVFY];
                    r_d.mpres = pwdata[hse_pkg::CTRL_MASK];
                    if (pwdata[hse_pkg::CTRL_CLEAR])
                    begin
                        r_d.size_known  = 1'b0;
                        r_d.field_known = 1'b0;
                    end
                end
                hse_pkg::OFF_SIZE:
                begin
                    r_d.size       = pwdata[7:0];
                    r_d.size_known = 1'b1;
                end
                hse_pkg::OFF_INDEX: r_d.index = pwdata[7:0];
                hse_pkg::OFF_MASK:  r_d.mask  = pwdata;
                hse_pkg::OFF_STATUS:
                    if (pwdata[hse_pkg::ST_VFY_FAIL])
                    begin
                        r_d.vfail = 1'b0;
                    end
                hse_pkg::OFF_ERRSET:
                begin
                    r_d.err_sub   = pwdata[7:0];
                    r_d.err_code  = pwdata[15:8];
                    r_d.err_mlen  = pwdata[23:16];
                    r_d.err_valid = (pwdata[15:8] != hse_pkg::CODE_OKAY)
                                 && (enc_total < hse_pkg::ENC_LIMIT);
                    r_d.err_len   = r_d.err_valid ? enc_total : 9'h000;
                end
                hse_pkg::OFF_VENDOR:
                begin
                    r_d.vend_type = pwdata[7:0];
                    r_d.vend_disc = (pwdata[7:0] != hse_pkg::VENDOR_ID_T);
                end
                default:
                    for (int w = 0; w < NWORD; w++)
                    begin
                        if (paddr == hse_pkg::OFF_FIELD + 12'(4 * w))
                        begin
                            {r_d.fld[4*w], r_d.fld[4*w+1],
                             r_d.fld[4*w+2], r_d.fld[4*w+3]} = pwdata;
                            r_d.field_known = 1'b1;
                        end
                    end
            endcase
        end

        // Byte stream, one byte per clock at most.
        case (r_q.state)
            hse_pkg::S_IDLE:
            begin
                r_d.cnt       = 6'h00;
                r_d.fail      = 1'b0;
                r_d.short_pkt = 1'b0;
                if (in_valid)
                begin
                    if (!active)
                        r_d.state = hse_pkg::S_PASS;
                    else if (r_q.down)
                        r_d.state = hse_pkg::S_SKIP;
                    else if (r_q.rx)
                        r_d.state = hse_pkg::S_REST;
                    else
                        r_d.state = hse_pkg::S_COLL;
                end
            end
            hse_pkg::S_PASS, hse_pkg::S_SKIP:
            begin
                in_ready = oslot;
                if (in_fire)
                begin
                    r_d.ovalid = 1'b1;
                    r_d.odata  = in_data;
                    r_d.olast  = in_last;
                    r_d.cnt    = 6'(r_q.cnt + 6'h01);
                    if (in_last)
                        r_d.state = hse_pkg::S_IDLE;
                    else if (r_q.state == hse_pkg::S_SKIP
                             && r_q.cnt == hse_pkg::DN_SKIP - 6'h01)
                    begin
                        r_d.cnt   = 6'h00;
                        r_d.state = r_q.rx ? hse_pkg::S_REST
                                           : hse_pkg::S_COLL;
                    end
                end
            end
            hse_pkg::S_COLL:
            begin
                in_ready = 1'b1;
                if (in_fire)
                begin
                    r_d.hold[r_q.cnt] = in_data;
                    // Only bytes that would be dropped are compared.
                    if (!r_q.novfy && mbit(r_q, r_q.cnt)
                        && in_data != r_q.fld[r_q.cnt])
                        r_d.fail = 1'b1;
                    r_d.cnt = 6'(r_q.cnt + 6'h01);
                    if (in_last || r_q.cnt == 6'(r_q.size - 8'h01))
                    begin
                        // A packet that ends inside the field is sent whole.
                        r_d.short_pkt = in_last;
                        r_d.tlast     = in_last;
                        r_d.n         = 6'(r_q.cnt + 6'h01);
                        r_d.cnt       = 6'h00;
                        r_d.state     = hse_pkg::S_EMIT;
                    end
                end
            end
            hse_pkg::S_EMIT:
            begin
                if (drop || oslot)
                begin
                    if (!drop)
                    begin
                        r_d.ovalid = 1'b1;
                        r_d.odata  = r_q.hold[r_q.cnt];
                        r_d.olast  = r_q.tlast
                                  && r_q.cnt == 6'(r_q.n - 6'h01);
                    end
                    r_d.cnt = 6'(r_q.cnt + 6'h01);
                    if (r_q.cnt == 6'(r_q.n - 6'h01))
                    begin
                        r_d.state = r_q.tlast ? hse_pkg::S_IDLE
                                              : hse_pkg::S_PASS;
                        if (r_q.fail)
                        begin
                            r_d.vfail    = 1'b1;
                            r_d.fail_cnt = 16'(r_q.fail_cnt + 16'h0001);
                        end
                        else if (!r_q.short_pkt)
                            r_d.sup_cnt = 16'(r_q.sup_cnt + 16'h0001);
                    end
                end
            end
            hse_pkg::S_REST:
            begin
                if (mbit(r_q, r_q.cnt))
                begin
                    if (oslot)
                    begin
                        r_d.ovalid = 1'b1;
                        r_d.odata  = r_q.fld[r_q.cnt];
                        r_d.olast  = 1'b0;
                        r_d.cnt    = 6'(r_q.cnt + 6'h01);
                    end
                end
                else
                begin
                    in_ready = oslot;
                    if (in_fire)
                    begin
                        r_d.ovalid = 1'b1;
                        r_d.odata  = in_data;
                        r_d.olast  = in_last;
                        r_d.cnt    = 6'(r_q.cnt + 6'h01);
                    end
                end
                if (r_d.cnt != r_q.cnt)
                begin
                    if (in_fire && in_last)
                        r_d.state = hse_pkg::S_IDLE;
                    else if (r_q.cnt == 6'(r_q.size - 8'h01))
                        r_d.state = hse_pkg::S_PASS;
                end
            end
            default: r_d.state = hse_pkg::S_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r_q       <= '0;
            r_q.state <= hse_pkg::S_IDLE;
            r_q.mask  <= hse_pkg::RST_MASK;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign prdata    = r_q.rdata;
    assign pready    = psel && penable;
    assign pslverr   = psel && penable && !mapped;
    assign out_valid = r_q.ovalid;
    assign out_data  = r_q.odata;
    assign out_last  = r_q.olast;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_up_noskip;
        r_q.state == hse_pkg::S_SKIP |-> r_q.down;
    endproperty
    a_up_noskip: assert property (p_up_noskip)
        else $error("skip state entered in upstream mode");

    property p_dn_skip;
        r_q.state == hse_pkg::S_SKIP && in_fire && !in_last
            && r_q.cnt == hse_pkg::DN_SKIP - 6'h01
        |=> r_q.state inside {hse_pkg::S_COLL, hse_pkg::S_REST};
    endproperty
    a_dn_skip: assert property (p_dn_skip)
        else $error("field not aligned after twelve skipped bytes");

    property p_fail_keep;
        r_q.state == hse_pkg::S_EMIT && r_q.fail && oslot
        |=> r_q.ovalid && r_q.odata == $past(r_q.hold[r_q.cnt]);
    endproperty
    a_fail_keep: assert property (p_fail_keep)
        else $error("byte dropped after verification failure");

    property p_inactive_pass;
        r_q.state == hse_pkg::S_IDLE && in_valid && !active
        |=> r_q.state == hse_pkg::S_PASS;
    endproperty
    a_inactive_pass: assert property (p_inactive_pass)
        else $error("partial or zero-size rule did not pass through");

    property p_code_nonzero;
        r_q.err_valid |-> r_q.err_code != hse_pkg::CODE_OKAY;
    endproperty
    a_code_nonzero: assert property (p_code_nonzero)
        else $error("error set holds success code");

    property p_enc_limit;
        r_q.err_len < hse_pkg::ENC_LIMIT;
    endproperty
    a_enc_limit: assert property (p_enc_limit)
        else $error("error encoding length not below limit");

    property p_ok_no_err;
        wr_en && paddr == hse_pkg::OFF_ERRSET
            && pwdata[15:8] == hse_pkg::CODE_OKAY
        |=> r_q.err_len == 9'h000 && !r_q.err_valid;
    endproperty
    a_ok_no_err: assert property (p_ok_no_err)
        else $error("error encoding built for accepted rule");

    property p_vendor;
        wr_en && paddr == hse_pkg::OFF_VENDOR
        |=> r_q.vend_disc == ($past(pwdata[7:0]) != hse_pkg::VENDOR_ID_T);
    endproperty
    a_vendor: assert property (p_vendor)
        else $error("vendor container discard flag wrong");

    property p_rest_cached;
        r_q.state == hse_pkg::S_REST && mbit(r_q, r_q.cnt) && oslot
        |-> !in_ready ##1 r_q.odata == r_q.fld[$past(r_q.cnt)];
    endproperty
    a_rest_cached: assert property (p_rest_cached)
        else $error("restored byte not taken from cached field");

    c_suppress: cover property (r_q.state == hse_pkg::S_EMIT && drop);
    c_vfail:    cover property ($rose(r_q.vfail));
    c_restore:  cover property (r_q.state == hse_pkg::S_REST && oslot);
    c_dnskip:   cover property (r_q.state == hse_pkg::S_SKIP
                                ##1 r_q.state == hse_pkg::S_COLL);

endmodule

// ==== tb/hse_peer_sink.sv ====
/* Peer entity that takes the output byte stream.
   Assumes out_* follow the ready/valid handshake on pclk. */
`timescale 1ns/1ps
module hse_peer_sink (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       out_valid,
    input  wire logic [7:0] out_data,
    input  wire logic       out_last,
    output logic            out_ready
);
    logic [7:0] got[$];
    logic [1:0] ph;
    int         n_last = 0;
    // Stalls one cycle in four so held output is exercised.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_ready <= 1'b0;
            ph <= 2'h0;
        end
        else
        begin
            ph <= ph + 2'h1;
            out_ready <= (ph != 2'h3);
            if (out_valid && out_ready)
            begin
                got.push_back(out_data);
                n_last <= n_last + int'(out_last);
            end
        end
    end
endmodule

// ==== tb/hse_bench.sv ====
/* Bench for hse_top: registers over APB, stream suppression, error set.
   Assumes hse_peer_sink as the far side of the output stream. */
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
 $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module header_suppression_engine_bench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, r;
    logic        pready, pslverr, err, in_ready, out_valid, out_last;
    logic        in_valid = 1'b0;
    logic        in_last = 1'b0;
    logic [7:0]  in_data = 8'h00;
    logic [7:0]  out_data;
    logic        out_ready;
    int          n_errors = 0;
    int          check_count = 0;
    hse_top hse_top_inst (.*);
    hse_peer_sink hse_peer_sink_inst (.*);
    always #2.5 pclk = ~pclk;
    task wrap_up;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        logic rdy;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge pclk);
            rdy = pready; r = prdata; err = pslverr;
            if (rdy === 1'b1) break;
        end
        if (rdy !== 1'b1) begin n_errors++; wrap_up; end
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task xfer(input logic [7:0] pk[$], input logic [7:0] ex[$]);
        int i, k, b, l;
        logic a;
        b = hse_peer_sink_inst.got.size();
        l = hse_peer_sink_inst.n_last;
        @(posedge pclk);
        for (i = 0; i < pk.size(); i++)
        begin
            in_valid <= 1'b1; in_data <= pk[i]; in_last <= (i == pk.size()-1);
            for (k = 0; k < 40; k++)
            begin
                @(posedge pclk);
                a = in_ready;
                if (a === 1'b1) break;
            end
            if (a !== 1'b1) begin n_errors++; wrap_up; end
        end
        in_valid <= 1'b0; in_last <= 1'b0;
        for (k = 0; k < 60; k++) @(posedge pclk);
        `CHK(hse_peer_sink_inst.got.size() - b, ex.size())
        `CHK(hse_peer_sink_inst.n_last - l, 1)
        for (i = 0; i < ex.size() && b + i < hse_peer_sink_inst.got.size(); i++)
            `CHK(hse_peer_sink_inst.got[b+i], ex[i])
    endtask
    task t_regs;
        apb(0, hse_pkg::OFF_MASK, 0); `CHK(r, hse_pkg::RST_MASK)
        apb(0, hse_pkg::OFF_STATUS, 0); `CHK(r, 32'h8)
        apb(0, 12'h3FC, 0); `CHK(err, 1'b1)
        apb(1, hse_pkg::OFF_VENDOR, 32'h5);
        apb(0, hse_pkg::OFF_STATUS, 0); `CHK(r[6], 1'b1)
        $display("test regs done");
    endtask
    task t_sup;
        apb(1, hse_pkg::OFF_CTRL, 32'h8);
        apb(1, hse_pkg::OFF_SIZE, 32'h2);
        apb(1, hse_pkg::OFF_MASK, 32'h8000_0000);
        apb(0, hse_pkg::OFF_STATUS, 0); `CHK(r[0], 1'b0)
        apb(1, hse_pkg::OFF_FIELD, 32'hAABB_0000);
        apb(0, hse_pkg::OFF_STATUS, 0); `CHK(r[0], 1'b1)
        xfer('{8'hAA, 8'hBB, 8'hCC, 8'hDD}, '{8'hBB, 8'hCC, 8'hDD});
        apb(0, hse_pkg::OFF_COUNT, 0); `CHK(r, 32'h1)
        xfer('{8'h11, 8'hBB, 8'hCC}, '{8'h11, 8'hBB, 8'hCC});
        apb(0, hse_pkg::OFF_STATUS, 0); `CHK(r[7], 1'b1)
        apb(1, hse_pkg::OFF_CTRL, 32'hC);
        xfer('{8'h11, 8'hBB, 8'hCC}, '{8'hBB, 8'hCC});
        apb(1, hse_pkg::OFF_CTRL, 32'h0);
        xfer('{8'hAA, 8'hBB, 8'hCC}, '{8'hCC});
        apb(1, hse_pkg::OFF_SIZE, 32'h0);
        xfer('{8'hAA, 8'hBB}, '{8'hAA, 8'hBB});
        $display("test suppress done");
    endtask
    task t_dir;
        logic [7:0] pk[$];
        logic [7:0] ex[$];
        apb(1, hse_pkg::OFF_SIZE, 32'h2);
        apb(1, hse_pkg::OFF_CTRL, 32'hA);
        for (int i = 0; i < 12; i++)
        begin
            pk.push_back(8'(i));
            ex.push_back(8'(i));
        end
        pk.push_back(8'hAA);
        pk.push_back(8'hBB);
        pk.push_back(8'hCC);
        ex.push_back(8'hBB);
        ex.push_back(8'hCC);
        xfer(pk, ex);
        apb(1, hse_pkg::OFF_CTRL, 32'h9);
        xfer('{8'hBB, 8'hCC}, '{8'hAA, 8'hBB, 8'hCC});
        $display("test direction done");
    endtask
    task t_err;
        apb(1, hse_pkg::OFF_ERRSET, 32'h04_09_01);
        apb(0, hse_pkg::OFF_ERRLEN, 0); `CHK(r, 32'hE)
        apb(1, hse_pkg::OFF_ERRSET, 32'h00_00_01);
        apb(0, hse_pkg::OFF_ERRLEN, 0); `CHK(r, 32'h0)
        apb(1, hse_pkg::OFF_ERRSET, 32'hF5_09_01);
        apb(0, hse_pkg::OFF_ERRLEN, 0); `CHK(r, 32'hFF)
        apb(1, hse_pkg::OFF_ERRSET, 32'hFF_09_01);
        apb(0, hse_pkg::OFF_ERRLEN, 0); `CHK(r, 32'h0)
        $display("test error set done");
    endtask
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_sup;
        t_dir;
        t_err;
        wrap_up;
    end
endmodule
